// *** verif/dofl_relay_model.sv ***
// relay bank that hangs on the terminal drive lines
// assumes one relay coil per terminal, driven low to pull in
`timescale 1ns/1ps
module dofl_relay_model #(
    parameter int N = 2
)(
    input  wire logic [N-1:0] drive_n_i,
    output logic      [N-1:0] relay_on_o
);
    // coil pulls in on low drive
    assign relay_on_o = ~drive_n_i;
endmodule // dofl_relay_model

// *** verif/drive_output_function_logic_tb_top.sv ***
// self-checking bench for the drive output function logic
// assumes the relay model is compiled before this file
`timescale 1ns/1ps
module drive_output_function_logic_tb_top;
    import dofl_pkg::*;
    localparam int FAN_LEN = 20;
    typedef struct {int sel; logic [15:0] exp;} dofl_note_t;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [15:0] out_freq_i = '0, max_freq_i = '0, desired_freq_i = '0;
    logic [15:0] out_curr_i = '0, brake_rel_i = 16'hFFFF, brake_eng_i = '0;
    logic        run_i = 1'b0, heat_warn_i = 1'b0, meter_src_i = 1'b0;
    logic        cnt_pulse_i = 1'b0, cnt_clear_i = 1'b0;
    logic        cnt_fault_en_i = 1'b0, fault_reset_i = 1'b0;
    logic [3:0]  pump_err_i = '0;
    logic [9:0]  term_func_i = '0;
    logic [7:0]  meter_gain_i = 8'h64;
    logic [13:0] term_cnt_i = '0, pre_cnt_i = '0;
    logic [2:0]  fan_mode_i = FAN_ALWAYS;
    logic [1:0]  term_out_n_o, term_fall_o, term_status_o, relay_on;
    logic [11:0] analog_meter_output_o;
    logic [13:0] cnt_value_o, cnt_disp_o;
    logic        cnt_disp_dot_o, external_fault_indication_o;
    logic        stop_req_o, fan_on_o, brake_on_o;
    dofl_note_t  notes[$];
    int          mismatches = 0;
    int          cmp_count = 0;
    int          i;
    logic [15:0] d;
    string nm[12] = '{"term_out_n", "term_status", "term_fall", "meter", "cnt_value",
        "cnt_disp", "cnt_dot", "ext_fault", "stop_req", "fan_on", "brake_on", "relay_on"};

    dofl_output_logic #(.NUM_TERM(2), .NUM_PUMP(4), .FAN_OFF_LEN(FAN_LEN)) u_dut (
        .clk_i, .srst_i, .out_freq_i, .max_freq_i, .desired_freq_i, .out_curr_i,
        .run_i, .heat_warn_i, .pump_err_i, .term_func_i, .meter_src_i,
        .meter_gain_i, .cnt_pulse_i, .cnt_clear_i, .term_cnt_i, .pre_cnt_i,
        .cnt_fault_en_i, .fault_reset_i, .fan_mode_i, .brake_rel_i, .brake_eng_i,
        .term_out_n_o, .term_fall_o, .term_status_o, .analog_meter_output_o,
        .cnt_value_o, .cnt_disp_o, .cnt_disp_dot_o, .external_fault_indication_o,
        .stop_req_o, .fan_on_o, .brake_on_o);

    dofl_relay_model #(.N(2)) u_relay (.drive_n_i(term_out_n_o), .relay_on_o(relay_on));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic tick(int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic put(int s, logic [15:0] e);
        notes.push_back('{s, e});
    endtask

    task automatic pulse(int n);
        repeat (n)
        begin
            cnt_pulse_i = 1'b1;
            tick(1);
            cnt_pulse_i = 1'b0;
            tick(1);
        end
        tick(2);
    endtask

    task automatic check(string name, logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [15:0] seen(int s);
        case (s)
            0: return 16'(term_out_n_o);
            1: return 16'(term_status_o);
            2: return 16'(term_fall_o);
            3: return 16'(analog_meter_output_o);
            4: return 16'(cnt_value_o);
            5: return 16'(cnt_disp_o);
            6: return 16'(cnt_disp_dot_o);
            7: return 16'(external_fault_indication_o);
            8: return 16'(stop_req_o);
            9: return 16'(fan_on_o);
            10: return 16'(brake_on_o);
            default: return 16'(relay_on);
        endcase
    endfunction

    // meter code from the tb's own view of source, gain and full scale
    function automatic logic [15:0] mexp();
        longint b, f, v;
        b = meter_src_i ? out_curr_i : out_freq_i;
        f = meter_src_i ? 2500 : max_freq_i;
        v = b * meter_gain_i * 4095 / (f * 100);
        return (v > 4095) ? 16'h0FFF : 16'(v);
    endfunction

    // registered outputs move on rising edges and the bench changes inputs at falling edges, so 1 ns past the falling edge is settled
    initial
    begin
        dofl_note_t n;
        forever
        begin
            @(negedge clk_i);
            #1;
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                check(nm[n.sel], seen(n.sel), n.exp);
            end
        end
    end

    initial
    begin
        #(60000 * 50);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(32'hABA83AEC));
        tick(6);
        srst_i = 1'b0;
        tick(1);
        put(0, 16'h0003);
        put(1, 16'h0003);
        put(3, 16'h0000);
        put(9, 16'h0001);
        d = 16'($urandom_range(59900, 1));
        desired_freq_i = d;
        term_func_i = {FN_NONE, FN_FREQ_ATT};
        out_freq_i = d - 16'h0001;
        tick(2);
        put(0, 16'h0003);
        out_freq_i = d;
        put(2, 16'h0001);
        tick(1);
        put(0, 16'h0002);
        put(1, 16'h0002);
        put(11, 16'h0001);
        put(2, 16'h0002);
        pump_err_i = 4'($urandom_range(15, 1));
        term_func_i = {FN_PUMP_ERR, FN_NONE};
        tick(2);
        put(0, 16'h0001);
        term_func_i = {5'h16, 5'h08};
        tick(2);
        put(0, 16'h0003);
        pump_err_i = 4'h0;
        for (i = 0; i < 8; i++)
        begin
            meter_src_i = i[0];
            meter_gain_i = (i < 2) ? 8'h64 : 8'($urandom_range(200, 1));
            max_freq_i = 16'($urandom_range(59900, 1));
            out_freq_i = (i < 2) ? max_freq_i : 16'($urandom_range(max_freq_i));
            out_curr_i = (i < 2) ? 16'h09C4 : 16'($urandom_range(3000));
            tick(2);
            put(3, mexp());
        end
        // a half-scale meter is given half gain by the user
        meter_src_i = SRC_FREQ;
        meter_gain_i = 8'h32;
        out_freq_i = max_freq_i;
        tick(2);
        put(3, 16'h07FF);
        term_func_i = {FN_PRE_CNT, FN_TERM_CNT};
        term_cnt_i = 14'h0003;
        pre_cnt_i = 14'h0002;
        cnt_fault_en_i = 1'b1;
        pulse(2);
        put(4, 16'h0002);
        put(0, 16'h0001);
        put(7, 16'h0000);
        pulse(1);
        put(0, 16'h0002);
        put(7, 16'h0001);
        put(8, 16'h0001);
        pulse(1);
        put(4, 16'h0003);
        fault_reset_i = 1'b1;
        cnt_clear_i = 1'b1;
        tick(2);
        fault_reset_i = 1'b0;
        cnt_clear_i = 1'b0;
        put(7, 16'h0000);
        put(4, 16'h0000);
        cnt_fault_en_i = 1'b0;
        term_cnt_i = 14'h0001;
        pre_cnt_i = 14'h0000;
        pulse(1);
        put(0, 16'h0002);
        put(7, 16'h0000);
        cnt_clear_i = 1'b1;
        term_cnt_i = 14'h0000;
        tick(2);
        cnt_clear_i = 1'b0;
        pulse(999);
        put(5, 16'h03E7);
        put(6, 16'h0000);
        pulse(6);
        put(5, 16'h0064);
        put(6, 16'h0001);
        fan_mode_i = FAN_RUN;
        tick(2);
        put(9, 16'h0000);
        run_i = 1'b1;
        tick(2);
        put(9, 16'h0001);
        fan_mode_i = FAN_DELAY;
        run_i = 1'b0;
        tick(3);
        put(9, 16'h0001);
        tick(FAN_LEN - 3);
        put(9, 16'h0001);
        tick(1);
        put(9, 16'h0000);
        fan_mode_i = FAN_HEAT;
        heat_warn_i = 1'b1;
        tick(2);
        put(9, 16'h0001);
        heat_warn_i = 1'b0;
        tick(2);
        put(9, 16'h0000);
        fan_mode_i = FAN_RUN_0HZ;
        run_i = 1'b1;
        out_freq_i = 16'h0000;
        tick(2);
        put(9, 16'h0000);
        out_freq_i = 16'h0100;
        tick(2);
        put(9, 16'h0001);
        run_i = 1'b0;
        tick(2);
        put(9, 16'h0000);
        term_func_i = {FN_NONE, FN_BRAKE};
        brake_rel_i = 16'h03E8;
        brake_eng_i = 16'h01F4;
        run_i = 1'b1;
        out_freq_i = 16'h03E7;
        tick(2);
        put(10, 16'h0000);
        out_freq_i = 16'h03E8;
        tick(2);
        put(10, 16'h0001);
        put(0, 16'h0002);
        out_freq_i = 16'h0190;
        tick(3);
        put(10, 16'h0001);
        run_i = 1'b0;
        tick(3);
        put(10, 16'h0000);
        put(0, 16'h0003);
        tick(3);
        print_verdict();
    end
endmodule // drive_output_function_logic_tb_top

// *** verilog/dofl_output_logic.sv ***
// output-side functions of a motor drive: terminal selectors, meter,
// event counter, fan and brake control
// assumes all inputs are synchronous to clk_i and come from the drive core
`timescale 1ns/1ps

// Overview of operation
// - code 9 asserts at desired frequency
// - meter source: frequency or current
// - frequency full scale at max frequency
// - current full scale at 2.5x rated
// - counter counts pulses, target 0 to 9999
// - code 10 asserts at terminal count
// - display count, divided by ten beyond digits
// - code 11 asserts at preliminary count
// - preliminary output drops at terminal count
// - option 1: terminal count raises external fault
// - option 0: terminal count raises no fault
// - fan modes 0, 1, 2
// - fan mode 3 follows heatsink warning
// - fan mode 4 runs, standby at 0 Hz
// - brake thresholds drive code 21 terminals
// - brake on at release, off after stop
// - code 23 on any pump error
// - status shows 0 on, 1 off
// - terminals are falling-edge triggered
module dofl_output_logic
    import dofl_pkg::*;
#(
    parameter int          NUM_TERM    = 2,
    parameter int          NUM_PUMP    = 4,
    parameter int unsigned FAN_OFF_LEN = dofl_pkg::FAN_OFF_CYC
)(
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic [dofl_pkg::FREQ_W-1:0] out_freq_i,
    input  wire logic [dofl_pkg::FREQ_W-1:0] max_freq_i,
    input  wire logic [dofl_pkg::FREQ_W-1:0] desired_freq_i,
    input  wire logic [15:0]                out_curr_i,
    input  wire logic                       run_i,
    input  wire logic                       heat_warn_i,
    input  wire logic [NUM_PUMP-1:0]        pump_err_i,
    input  wire logic [NUM_TERM*dofl_pkg::FUNC_W-1:0] term_func_i,
    input  wire logic                       meter_src_i,
    input  wire logic [7:0]                 meter_gain_i,
    input  wire logic                       cnt_pulse_i,
    input  wire logic                       cnt_clear_i,
    input  wire logic [dofl_pkg::CNT_W-1:0] term_cnt_i,
    input  wire logic [dofl_pkg::CNT_W-1:0] pre_cnt_i,
    input  wire logic                       cnt_fault_en_i,
    input  wire logic                       fault_reset_i,
    input  wire logic [2:0]                 fan_mode_i,
    input  wire logic [dofl_pkg::FREQ_W-1:0] brake_rel_i,
    input  wire logic [dofl_pkg::FREQ_W-1:0] brake_eng_i,
    output logic [NUM_TERM-1:0]             term_out_n_o,
    output logic [NUM_TERM-1:0]             term_fall_o,
    output logic [NUM_TERM-1:0]             term_status_o,
    output logic [dofl_pkg::METER_W-1:0]    analog_meter_output_o,
    output logic [dofl_pkg::CNT_W-1:0]      cnt_value_o,
    output logic [dofl_pkg::CNT_W-1:0]      cnt_disp_o,
    output logic                            cnt_disp_dot_o,
    output logic                            external_fault_indication_o,
    output logic                            stop_req_o,
    output logic                            fan_on_o,
    output logic                            brake_on_o
);
    import dofl_pkg::*;

    logic [CNT_W-1:0]    count;
    logic                pulse_d;
    logic                term_hit_d;
    logic                fault;
    logic                stopped;
    logic                brake;
    logic [31:0]         fan_tmr;
    dofl_fan_t           fan_st;
    dofl_fan_t           next_fan_st;
    logic [NUM_TERM-1:0] term_on;
    logic [NUM_TERM-1:0] next_term_on;
    logic [METER_W-1:0]  meter;

    // event and threshold conditions
    wire freq_att  = (out_freq_i >= desired_freq_i);
    wire pulse_rise = cnt_pulse_i & ~pulse_d;
    wire term_hit  = (term_cnt_i != '0) && (count >= term_cnt_i);
    wire pre_hit   = (pre_cnt_i != '0) && (count >= pre_cnt_i) && !term_hit;
    wire pump_err  = |pump_err_i;
    wire brk_set   = (out_freq_i >= brake_rel_i);
    wire brk_clr   = stopped && (out_freq_i <= brake_eng_i);
    wire fan_last  = (fan_tmr >= FAN_OFF_LEN - 32'd1);

    // routes one condition to a terminal by its function code
    function automatic logic route(input logic [FUNC_W-1:0] code);
        case (code)
            FN_FREQ_ATT: route = freq_att;
            FN_TERM_CNT: route = term_hit;
            FN_PRE_CNT:  route = pre_hit;
            FN_BRAKE:    route = brake;
            FN_PUMP_ERR: route = pump_err;
            default:     route = 1'b0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_TERM; g++)
        begin : g_term
            assign next_term_on[g] = route(term_func_i[g*FUNC_W +: FUNC_W]);
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            term_on <= '0;
        else
            term_on <= next_term_on;
    end

    // active-low drive, falling edge marks turn-on
    assign term_out_n_o  = ~term_on;
    assign term_fall_o   = next_term_on & ~term_on;
    assign term_status_o = ~term_on;

    // event counter, holds once the target is reached
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            count   <= '0;
            pulse_d <= 1'b0;
        end
        else
        begin
            pulse_d <= cnt_pulse_i;
            if (cnt_clear_i)
                count <= '0;
            else if (pulse_rise && !term_hit && count < CNT_MAX)
                count <= count + 1'b1;
        end
    end

    // display beyond three digits shows count/10 with a dot
    assign cnt_value_o    = count;
    assign cnt_disp_dot_o = (count > DISP_MAX);
    assign cnt_disp_o     = cnt_disp_dot_o ? CNT_W'(count / DISP_DIV) : count;

    // fault on reaching the target; set wins over reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            fault      <= 1'b0;
            term_hit_d <= 1'b0;
        end
        else
        begin
            term_hit_d <= term_hit;
            if (term_hit && !term_hit_d && cnt_fault_en_i)
                fault <= 1'b1;
            else if (fault_reset_i)
                fault <= 1'b0;
        end
    end

    assign external_fault_indication_o = fault;
    assign stop_req_o                  = fault;

    // meter scaling; gain is in percent
    wire [15:0] m_base = (meter_src_i == SRC_CURR) ? out_curr_i : out_freq_i;
    wire [15:0] m_full = (meter_src_i == SRC_CURR) ? CURR_FS : max_freq_i;
    wire [35:0] m_num  = 36'(m_base) * 36'(meter_gain_i) * 36'(METER_FS);
    wire [35:0] m_den  = 36'(m_full) * 36'(GAIN_UNITY);
    wire [35:0] m_quo  = (m_den == '0) ? '0 : m_num / m_den;
    wire [METER_W-1:0] next_meter =
        (m_quo > 36'(METER_FS)) ? METER_FS : m_quo[METER_W-1:0];

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            meter <= '0;
        else
            meter <= next_meter;
    end

    assign analog_meter_output_o = meter;

    // brake: release at threshold, engage only after a stop
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            brake   <= 1'b0;
            stopped <= 1'b0;
        end
        else
        begin
            stopped <= !run_i;
            if (brk_set)
                brake <= 1'b1;
            else if (brk_clr)
                brake <= 1'b0;
        end
    end

    assign brake_on_o = brake;

    always_comb
    begin
        next_fan_st = DOFL_FAN_OFF;
        case (fan_mode_i)
            FAN_ALWAYS:
                next_fan_st = DOFL_FAN_ON;
            FAN_DELAY:
                if (run_i)
                    next_fan_st = DOFL_FAN_ON;
                else if (fan_st == DOFL_FAN_OFF || (fan_st == DOFL_FAN_HOLD && fan_last))
                    next_fan_st = DOFL_FAN_OFF;
                else
                    next_fan_st = DOFL_FAN_HOLD;
            FAN_RUN:
                next_fan_st = run_i ? DOFL_FAN_ON : DOFL_FAN_OFF;
            FAN_HEAT:
                next_fan_st = heat_warn_i ? DOFL_FAN_ON : DOFL_FAN_OFF;
            FAN_RUN_0HZ:
                // zero output frequency parks the fan in standby
                next_fan_st = (run_i && out_freq_i != '0) ? DOFL_FAN_ON : DOFL_FAN_OFF;
            default:
                next_fan_st = DOFL_FAN_ON;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            fan_st  <= DOFL_FAN_ON;
            fan_tmr <= '0;
        end
        else
        begin
            fan_st  <= next_fan_st;
            fan_tmr <= (next_fan_st == DOFL_FAN_HOLD && fan_st == DOFL_FAN_HOLD)
                       ? fan_tmr + 32'd1 : '0;
        end
    end

    assign fan_on_o = (fan_st != DOFL_FAN_OFF);

    // checks; terminal routing checks are watched on terminal 0 only
    wire [FUNC_W-1:0] code0 = term_func_i[FUNC_W-1:0];

    chk_code_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_NONE |=> !term_on[0])
        else $error("terminal active with code 0");

    chk_freq_attain: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_FREQ_ATT && freq_att |=> term_out_n_o[0] == 1'b0)
        else $error("frequency attained not driven");

    chk_count_attain: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_TERM_CNT && term_hit |=> term_on[0] && !term_status_o[0])
        else $error("terminal count not driven");

    chk_prelim_attain: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_PRE_CNT && count >= pre_cnt_i && pre_cnt_i != '0 && !term_hit
        |=> term_on[0])
        else $error("preliminary count not driven");

    chk_prelim_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_PRE_CNT && term_hit |=> !term_on[0])
        else $error("preliminary output held at terminal count");

    chk_count_range: assert property (@(posedge clk_i) disable iff (srst_i)
        count <= CNT_MAX)
        else $error("counter beyond its limit");

    chk_count_step: assert property (@(posedge clk_i) disable iff (srst_i)
        pulse_rise && !term_hit && !cnt_clear_i && count < CNT_MAX
        |=> count == $past(count) + 1'b1)
        else $error("counter step wrong");

    chk_disp_small: assert property (@(posedge clk_i) disable iff (srst_i)
        count <= DISP_MAX |-> !cnt_disp_dot_o && cnt_disp_o == count)
        else $error("display split below the digit limit");

    chk_fault_set: assert property (@(posedge clk_i) disable iff (srst_i)
        term_hit && !term_hit_d && cnt_fault_en_i |=> fault && stop_req_o)
        else $error("count fault not raised");

    chk_no_fault: assert property (@(posedge clk_i) disable iff (srst_i)
        !fault && !cnt_fault_en_i |=> !external_fault_indication_o)
        else $error("fault raised with option 0");

    chk_fan_always: assert property (@(posedge clk_i) disable iff (srst_i)
        fan_mode_i == FAN_ALWAYS |=> fan_on_o)
        else $error("fan off in mode 0");

    chk_fan_heat: assert property (@(posedge clk_i) disable iff (srst_i)
        fan_mode_i == FAN_HEAT |=> fan_on_o == $past(heat_warn_i))
        else $error("fan not following heatsink warning");

    chk_fan_standby: assert property (@(posedge clk_i) disable iff (srst_i)
        fan_mode_i == FAN_RUN_0HZ && out_freq_i == '0 |=> !fan_on_o)
        else $error("fan running at 0 Hz in mode 4");

    chk_fan_run: assert property (@(posedge clk_i) disable iff (srst_i)
        fan_mode_i == FAN_RUN |=> fan_on_o == $past(run_i))
        else $error("fan not following run in mode 2");

    chk_fan_delay: assert property (@(posedge clk_i) disable iff (srst_i)
        fan_mode_i == FAN_DELAY && run_i |=> fan_on_o)
        else $error("fan off while running in mode 1");

    chk_brake_release: assert property (@(posedge clk_i) disable iff (srst_i)
        brk_set |=> brake_on_o)
        else $error("brake not released at threshold");

    chk_brake_route: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_BRAKE |=> term_on[0] == $past(brake))
        else $error("brake condition not routed");

    chk_brake_engage: assert property (@(posedge clk_i) disable iff (srst_i)
        brk_clr && !brk_set |=> !brake_on_o)
        else $error("brake not engaged after stop");

    chk_brake_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        brake && !stopped && !brk_set |=> brake_on_o)
        else $error("brake engaged while running");

    chk_meter_full: assert property (@(posedge clk_i) disable iff (srst_i)
        meter_src_i == SRC_FREQ && meter_gain_i == GAIN_UNITY
        && out_freq_i == max_freq_i && max_freq_i != '0 |=> meter == METER_FS)
        else $error("meter not full scale at max frequency");

    chk_meter_curr: assert property (@(posedge clk_i) disable iff (srst_i)
        meter_src_i == SRC_CURR && meter_gain_i == GAIN_UNITY && out_curr_i == CURR_FS
        |=> meter == METER_FS)
        else $error("meter not full scale at 250 percent current");

    chk_pump_err: assert property (@(posedge clk_i) disable iff (srst_i)
        code0 == FN_PUMP_ERR |=> term_on[0] == $past(|pump_err_i))
        else $error("pump error not routed");

    chk_term_fall: assert property (@(posedge clk_i) disable iff (srst_i)
        term_fall_o[0] |=> !term_out_n_o[0])
        else $error("falling mark without terminal drive");

endmodule // dofl_output_logic

// *** verilog/dofl_pkg.sv ***
// constants for the drive output function logic
// assumes a 20 MHz system clock and synchronous inputs from the drive core
package dofl_pkg;
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned FAN_OFF_S   = 60;
    localparam int unsigned FAN_OFF_CYC = FAN_OFF_S * CLK_HZ;

    localparam int          FUNC_W      = 5;
    localparam int          FREQ_W      = 16;
    localparam int          CNT_W       = 14;
    localparam int          METER_W     = 12;

    // terminal function codes
    localparam logic [4:0]  FN_NONE     = 5'h00;
    localparam logic [4:0]  FN_FREQ_ATT = 5'h09;
    localparam logic [4:0]  FN_TERM_CNT = 5'h0A;
    localparam logic [4:0]  FN_PRE_CNT  = 5'h0B;
    localparam logic [4:0]  FN_BRAKE    = 5'h15;
    localparam logic [4:0]  FN_PUMP_ERR = 5'h17;

    // counter limits and display split
    localparam logic [13:0] CNT_MAX     = 14'h270F;
    localparam logic [13:0] DISP_MAX    = 14'h03E7;
    localparam logic [13:0] DISP_DIV    = 14'h000A;

    // meter scaling: full scale code is +10 V
    localparam logic [11:0] METER_FS    = 12'hFFF;
    localparam logic [7:0]  GAIN_UNITY  = 8'h64;
    localparam logic [15:0] CURR_FS     = 16'h09C4;
    localparam logic        SRC_FREQ    = 1'b0;
    localparam logic        SRC_CURR    = 1'b1;

    // fan modes
    localparam logic [2:0]  FAN_ALWAYS  = 3'h0;
    localparam logic [2:0]  FAN_DELAY   = 3'h1;
    localparam logic [2:0]  FAN_RUN     = 3'h2;
    localparam logic [2:0]  FAN_HEAT    = 3'h3;
    localparam logic [2:0]  FAN_RUN_0HZ = 3'h4;

    typedef enum logic [1:0] {
        DOFL_FAN_OFF  = 2'b00,
        DOFL_FAN_ON   = 2'b01,
        DOFL_FAN_HOLD = 2'b11
    } dofl_fan_t;
endpackage
